// File: rtl/cfg_target_regs.svh
// configuration header offsets, field values, reset values and bus codes
`ifndef CFG_TARGET_REGS_SVH
`define CFG_TARGET_REGS_SVH

// ****************************************************************
// header byte offsets (byte address = {index, 2'b00})
// ****************************************************************
`define CFG_OFS_IDENT        8'h00
`define CFG_OFS_CMD_STATE    8'h04
`define CFG_OFS_CLASS_REV    8'h08
`define CFG_OFS_HDR_LAT      8'h0c
`define CFG_OFS_WIN_BASE     8'h10
`define CFG_OFS_INT_GNT      8'h3c

// ****************************************************************
// field masks and fixed values
// ****************************************************************
`define CFG_CMD_RW_MASK      32'h0000_0146
`define CFG_STAT_W1C_MASK    32'hf900_0000
`define CFG_SEL_TIMING       2'h1
`define CFG_FAST_B2B         1'h1
`define CFG_CLASS_CODE       24'h040000
`define CFG_HEADER_TYPE      8'h00
`define CFG_WIN_LOW_BITS     12'h008
`define CFG_WIN_RW_MASK      32'hffff_f000
`define CFG_LAT_RW_MASK      32'h0000_ff00
`define CFG_INTLINE_RW_MASK  32'h0000_00ff

// ****************************************************************
// reset values of writable fields
// ****************************************************************
`define CFG_RST_LATENCY      8'h00
`define CFG_RST_WIN_BASE     20'h00000
`define CFG_RST_INT_LINE     8'h00

// ****************************************************************
// bus command codes
// ****************************************************************
`define BUS_CMD_CFG_RD       4'ha
`define BUS_CMD_CFG_WR       4'hb
`define BUS_CMD_MEM_RD       4'h6
`define BUS_CMD_MEM_WR       4'h7
`define BUS_CMD_MEM_RD_MUL   4'hc
`define BUS_CMD_MEM_RD_LINE  4'he
`define BUS_CMD_MEM_WR_INV   4'hf

`endif

// File: rtl/cfg_target_pkg.sv
// types shared by the configuration target and its helpers
package cfg_target_pkg;

  // target sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CLAIM = 2'b01,
    ST_XFER  = 2'b10,
    ST_TURN  = 2'b11
  } tgt_state_t;

  // sampled bus pins
  typedef struct packed {
    logic        frame_n;
    logic        irdy_n;
    logic        idsel;
    logic [3:0]  cbe_n;
    logic [31:0] ad;
  } bus_in_t;

  // driven bus pins with enables
  typedef struct packed {
    logic [31:0] ad;
    logic        ad_oe;
    logic        trdy_n;
    logic        devsel_n;
    logic        stop_n;
    logic        ctl_oe;
  } bus_out_t;

  // status event pulses from the rest of the device
  typedef struct packed {
    logic det_parity;
    logic sig_serr;
    logic rcv_mabort;
    logic rcv_tabort;
    logic sig_tabort;
    logic data_parity;
  } status_ev_t;

  // writable configuration state
  typedef struct packed {
    logic        serr_en;
    logic        perr_resp;
    logic        bus_master;
    logic        mem_space;
    status_ev_t  status;
    logic [7:0]  latency;
    logic [19:0] win_base;
    logic [7:0]  int_line;
  } cfg_regs_t;

  // settings seen by the rest of the device
  typedef struct packed {
    logic        mem_space_en;
    logic        bus_master_en;
    logic        perr_resp_en;
    logic        serr_en;
    logic [7:0]  latency;
    logic [19:0] win_base;
    logic [7:0]  int_line;
  } cfg_ctrl_t;

  // whole state of the target
  typedef struct packed {
    tgt_state_t  state;
    logic        frame_prev;
    logic        write;
    logic [5:0]  idx;
    bus_out_t    pins;
    cfg_regs_t   cfg;
    logic        mem_hit;
  } tgt_regs_t;

  // state of the parity driver
  typedef struct packed {
    logic par;
    logic par_oe;
  } par_state_t;

endpackage

// File: rtl/cfg_byte_merge.sv
// merges a configuration write into a dword, lane by lane
`timescale 1ns/10ps
module cfg_byte_merge (
  // current and written dword
  input  wire logic [31:0] old_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  be_n_i,
  // bit classes of the addressed register
  input  wire logic [31:0] rw_mask_i,
  input  wire logic [31:0] w1c_mask_i,
  // merged result
  output logic      [31:0] new_o
);

  // each enabled lane takes writable bits, clears written ones of w1c bits
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      logic [7:0] o, w, rw, wc;
      assign o  = old_i[lane*8 +: 8];
      assign w  = wdata_i[lane*8 +: 8];
      assign rw = rw_mask_i[lane*8 +: 8];
      assign wc = w1c_mask_i[lane*8 +: 8];
      assign new_o[lane*8 +: 8] = be_n_i[lane] ? o :
                                  (o & ~rw & ~wc) | (w & rw) |
                                  (o & wc & ~w);
    end
  endgenerate

endmodule

// File: rtl/cfg_parity_drive.sv
// drives even parity one clock after the data it covers
`timescale 1ns/10ps
module cfg_parity_drive (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  // data phase being driven
  input  wire logic [31:0] ad_i,
  input  wire logic [3:0]  cbe_n_i,
  input  wire logic        ad_oe_i,
  // parity pin
  output logic             par_o,
  output logic             par_oe_o
);

  cfg_target_pkg::par_state_t st_r, st_nxt;

  // parity over data and byte enables, enable follows data enable
  always_comb begin
    st_nxt        = st_r;
    st_nxt.par    = ^{ad_i, cbe_n_i};
    st_nxt.par_oe = ad_oe_i;
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign par_o    = st_r.par;
  assign par_oe_o = st_r.par_oe;

endmodule

// File: rtl/pci_config_space_target.sv
// configuration space target of the capture device, with 64-byte header
`timescale 1ns/10ps
`include "cfg_target_regs.svh"
module pci_config_space_target #(
  parameter logic [15:0] DEVICE_CODE = 16'h0abc, // arbitrary value
  parameter logic [15:0] VENDOR_CODE = 16'h0def, // arbitrary value
  parameter logic [7:0]  REVISION    = 8'h00,
  parameter logic [7:0]  INT_PIN     = 8'h01,
  parameter logic [7:0]  MIN_GRANT   = 8'h00,
  parameter logic [7:0]  MAX_LATENCY = 8'h00
) (
  // clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      nrst_i,
  // bus pins in
  input  wire logic                      frame_n_i,
  input  wire logic                      irdy_n_i,
  input  wire logic                      idsel_i,
  input  wire logic [3:0]                cbe_n_i,
  input  wire logic [31:0]               ad_i,
  // bus pins out
  output logic      [31:0]               ad_o,
  output logic                           ad_oe_o,
  output logic                           trdy_n_o,
  output logic                           devsel_n_o,
  output logic                           stop_n_o,
  output logic                           ctl_oe_o,
  output logic                           par_o,
  output logic                           par_oe_o,
  // events and settings of the rest of the device
  input  wire cfg_target_pkg::status_ev_t status_ev_i,
  output cfg_target_pkg::cfg_ctrl_t       ctrl_o,
  output logic                           mem_hit_o
);

  // ****************************************************************
  // decoding helpers
  // ****************************************************************

  // true for a memory space command
  function automatic logic is_mem_cmd(input logic [3:0] cmd);
    is_mem_cmd = (cmd == `BUS_CMD_MEM_RD) || (cmd == `BUS_CMD_MEM_WR) ||
                 (cmd == `BUS_CMD_MEM_RD_MUL) || (cmd == `BUS_CMD_MEM_RD_LINE) ||
                 (cmd == `BUS_CMD_MEM_WR_INV);
  endfunction

  // true for a configuration command
  function automatic logic is_cfg_cmd(input logic [3:0] cmd);
    is_cfg_cmd = (cmd == `BUS_CMD_CFG_RD) || (cmd == `BUS_CMD_CFG_WR);
  endfunction

  // index of a header offset
  function automatic logic [5:0] ofs_idx(input logic [7:0] ofs);
    ofs_idx = ofs[7:2];
  endfunction

  // dword view of the header at one index
  function automatic logic [31:0] cfg_read(input logic [5:0]               idx,
                                           input cfg_target_pkg::cfg_regs_t c);
    cfg_read = 32'h0000_0000;
    unique case (idx)
      ofs_idx(`CFG_OFS_IDENT): begin
        cfg_read = {DEVICE_CODE, VENDOR_CODE};
      end
      ofs_idx(`CFG_OFS_CMD_STATE): begin
        cfg_read = {c.status.det_parity, c.status.sig_serr,
                    c.status.rcv_mabort, c.status.rcv_tabort,
                    c.status.sig_tabort, `CFG_SEL_TIMING,
                    c.status.data_parity, `CFG_FAST_B2B,
                    7'h00, 7'h00, c.serr_en, 1'b0, c.perr_resp,
                    3'h0, c.bus_master, c.mem_space, 1'b0};
      end
      ofs_idx(`CFG_OFS_CLASS_REV): begin
        cfg_read = {`CFG_CLASS_CODE, REVISION};
      end
      ofs_idx(`CFG_OFS_HDR_LAT): begin
        cfg_read = {8'h00, `CFG_HEADER_TYPE, c.latency, 8'h00};
      end
      ofs_idx(`CFG_OFS_WIN_BASE): begin
        cfg_read = {c.win_base, `CFG_WIN_LOW_BITS};
      end
      ofs_idx(`CFG_OFS_INT_GNT): begin
        cfg_read = {MAX_LATENCY, MIN_GRANT, INT_PIN, c.int_line};
      end
      default: begin
        cfg_read = 32'h0000_0000;
      end
    endcase
  endfunction

  // writable bits of the register at one index
  function automatic logic [31:0] rw_mask(input logic [5:0] idx);
    unique case (idx)
      ofs_idx(`CFG_OFS_CMD_STATE): rw_mask = `CFG_CMD_RW_MASK;
      ofs_idx(`CFG_OFS_HDR_LAT):   rw_mask = `CFG_LAT_RW_MASK;
      ofs_idx(`CFG_OFS_WIN_BASE):  rw_mask = `CFG_WIN_RW_MASK;
      ofs_idx(`CFG_OFS_INT_GNT):   rw_mask = `CFG_INTLINE_RW_MASK;
      default:                     rw_mask = 32'h0000_0000;
    endcase
  endfunction

  // ****************************************************************
  // state and write path
  // ****************************************************************

  cfg_target_pkg::tgt_regs_t st_r, st_nxt;
  logic [31:0] wr_old;
  logic [31:0] wr_new;
  logic [31:0] wr_w1c;
  logic        addr_phase;
  logic        cfg_claim;
  logic        mem_claim;
  logic        beat;
  logic [5:0]  rd_idx;

  // the dword a write lands on, seen as the bus reads it
  assign wr_old = cfg_read(st_r.idx, st_r.cfg);
  assign wr_w1c = (st_r.idx == ofs_idx(`CFG_OFS_CMD_STATE)) ?
                  `CFG_STAT_W1C_MASK : 32'h0000_0000;

  // lane-wise merge of written data
  cfg_byte_merge u_merge (
    .old_i      (wr_old),
    .wdata_i    (ad_i),
    .be_n_i     (cbe_n_i),
    .rw_mask_i  (rw_mask(st_r.idx)),
    .w1c_mask_i (wr_w1c),
    .new_o      (wr_new)
  );

  // address phase: first clock of frame low
  assign addr_phase = !frame_n_i && st_r.frame_prev;

  // claim a type 0 cycle; function bits AD[10:8] are not looked at
  assign cfg_claim = addr_phase && idsel_i &&
                     (ad_i[1:0] == 2'b00) &&
                     is_cfg_cmd(cbe_n_i);

  // memory window hit, only when memory space is enabled
  assign mem_claim = addr_phase && !idsel_i && is_mem_cmd(cbe_n_i) &&
                     st_r.cfg.mem_space &&
                     (ad_i[31:12] == st_r.cfg.win_base);

  // one data phase completes
  assign beat = (st_r.state == cfg_target_pkg::ST_XFER) && !irdy_n_i &&
                !st_r.pins.trdy_n;

  // index of the next read data
  assign rd_idx = beat ? st_r.idx + 6'h01 : st_r.idx;

  // ****************************************************************
  // next state
  // ****************************************************************

  always_comb begin
    st_nxt            = st_r;
    st_nxt.frame_prev = frame_n_i;
    st_nxt.mem_hit    = mem_claim;

    // configuration writes, only on a completed beat of a write
    if (beat && st_r.write) begin
      unique case (st_r.idx)
        ofs_idx(`CFG_OFS_CMD_STATE): begin
          st_nxt.cfg.serr_en            = wr_new[8];
          st_nxt.cfg.perr_resp          = wr_new[6];
          st_nxt.cfg.bus_master         = wr_new[2];
          st_nxt.cfg.mem_space          = wr_new[1];
          st_nxt.cfg.status.det_parity  = wr_new[31];
          st_nxt.cfg.status.sig_serr    = wr_new[30];
          st_nxt.cfg.status.rcv_mabort  = wr_new[29];
          st_nxt.cfg.status.rcv_tabort  = wr_new[28];
          st_nxt.cfg.status.sig_tabort  = wr_new[27];
          st_nxt.cfg.status.data_parity = wr_new[24];
        end
        ofs_idx(`CFG_OFS_HDR_LAT): begin
          st_nxt.cfg.latency = wr_new[15:8];
        end
        ofs_idx(`CFG_OFS_WIN_BASE): begin
          st_nxt.cfg.win_base = wr_new[31:12];
        end
        ofs_idx(`CFG_OFS_INT_GNT): begin
          st_nxt.cfg.int_line = wr_new[7:0];
        end
        default: begin
          st_nxt.cfg = st_r.cfg;
        end
      endcase
    end

    // events set status bits; a set beats a clear in the same cycle
    st_nxt.cfg.status = st_nxt.cfg.status | status_ev_i;

    // bus sequencer
    unique case (st_r.state)
      cfg_target_pkg::ST_IDLE: begin
        st_nxt.pins.ad_oe    = 1'b0;
        st_nxt.pins.ctl_oe   = 1'b0;
        st_nxt.pins.trdy_n   = 1'b1;
        st_nxt.pins.devsel_n = 1'b1;
        st_nxt.pins.stop_n   = 1'b1;
        if (cfg_claim) begin
          st_nxt.state = cfg_target_pkg::ST_CLAIM;
          st_nxt.idx   = ad_i[7:2];
          st_nxt.write = (cbe_n_i == `BUS_CMD_CFG_WR);
        end
      end
      cfg_target_pkg::ST_CLAIM: begin
        // select goes low one clock late: medium timing
        st_nxt.state         = cfg_target_pkg::ST_XFER;
        st_nxt.pins.ctl_oe   = 1'b1;
        st_nxt.pins.devsel_n = 1'b0;
        st_nxt.pins.trdy_n   = 1'b0;
        st_nxt.pins.ad_oe    = !st_r.write;
        st_nxt.pins.ad       = cfg_read(rd_idx, st_r.cfg);
      end
      cfg_target_pkg::ST_XFER: begin
        if (beat) begin
          st_nxt.idx = rd_idx;
        end
        if (beat && frame_n_i) begin
          // last data phase done: release the bus
          st_nxt.state         = cfg_target_pkg::ST_TURN;
          st_nxt.pins.trdy_n   = 1'b1;
          st_nxt.pins.devsel_n = 1'b1;
          st_nxt.pins.ad_oe    = 1'b0;
        end else if (!st_r.write) begin
          st_nxt.pins.ad = cfg_read(rd_idx, st_r.cfg);
        end
      end
      cfg_target_pkg::ST_TURN: begin
        // controls driven high for one clock, then released
        st_nxt.state       = cfg_target_pkg::ST_IDLE;
        st_nxt.pins.ctl_oe = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r               <= '0;
      st_r.state         <= cfg_target_pkg::ST_IDLE;
      st_r.frame_prev    <= 1'b1;
      st_r.pins.trdy_n   <= 1'b1;
      st_r.pins.devsel_n <= 1'b1;
      st_r.pins.stop_n   <= 1'b1;
      st_r.cfg.latency   <= `CFG_RST_LATENCY;
      st_r.cfg.win_base  <= `CFG_RST_WIN_BASE;
      st_r.cfg.int_line  <= `CFG_RST_INT_LINE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // parity and outputs
  // ****************************************************************

  // parity follows read data by one clock
  cfg_parity_drive u_par (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .ad_i      (st_r.pins.ad),
    .cbe_n_i   (cbe_n_i),
    .ad_oe_i   (st_r.pins.ad_oe),
    .par_o     (par_o),
    .par_oe_o  (par_oe_o)
  );

  // pin drivers
  assign ad_o       = st_r.pins.ad;
  assign ad_oe_o    = st_r.pins.ad_oe;
  assign trdy_n_o   = st_r.pins.trdy_n;
  assign devsel_n_o = st_r.pins.devsel_n;
  assign stop_n_o   = st_r.pins.stop_n;
  assign ctl_oe_o   = st_r.pins.ctl_oe;

  // settings for the rest of the device; zero command disables all
  assign ctrl_o.mem_space_en  = st_r.cfg.mem_space;
  assign ctrl_o.bus_master_en = st_r.cfg.bus_master;
  assign ctrl_o.perr_resp_en  = st_r.cfg.perr_resp;
  assign ctrl_o.serr_en       = st_r.cfg.serr_en;
  assign ctrl_o.latency       = st_r.cfg.latency;
  assign ctrl_o.win_base      = st_r.cfg.win_base;
  assign ctrl_o.int_line      = st_r.cfg.int_line;
  assign mem_hit_o            = st_r.mem_hit;

endmodule

// File: tb/pci_config_space_target_assertions.sv
// pin-level checks of the configuration target
`timescale 1ns/10ps
module pci_config_space_target_assertions (
  // clock and reset
  input wire logic                      sys_clk_i,
  input wire logic                      nrst_i,
  // bus pins
  input wire logic                      frame_n_i,
  input wire logic                      irdy_n_i,
  input wire logic                      idsel_i,
  input wire logic [3:0]                cbe_n_i,
  input wire logic [31:0]               ad_i,
  input wire logic                      ad_oe_o,
  input wire logic                      trdy_n_o,
  input wire logic                      devsel_n_o,
  input wire logic                      stop_n_o,
  input wire logic                      ctl_oe_o,
  // window decode
  input wire cfg_target_pkg::cfg_ctrl_t ctrl_o,
  input wire logic                      mem_hit_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ****************************************************************
  // address phase and beat detection
  // ****************************************************************
  logic frame_q;
  logic start_w;
  logic cfg_w;
  logic beat_w;
  // frame level at the previous edge
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_q <= 1'b1;
    end else begin
      frame_q <= frame_n_i;
    end
  end
  // command a or b both match 101x
  assign start_w = frame_q && !frame_n_i;
  assign cfg_w = start_w && idsel_i && ad_i[1:0] == 2'h0 && cbe_n_i[3:1] == 3'h5;
  assign beat_w = !irdy_n_i && !trdy_n_o;

  // ****************************************************************
  // assertions
  // ****************************************************************
  chk_claim_medium: assert property (
    cfg_w |=> devsel_n_o ##1 (!devsel_n_o && !trdy_n_o && ctl_oe_o)) else $error("late claim");
  chk_read_drive: assert property (
    cfg_w && cbe_n_i[0] == 1'b0 |-> ##2 ad_oe_o) else $error("read data not driven");
  chk_write_quiet: assert property (
    cfg_w && cbe_n_i[0] |-> ##2 !ad_oe_o ##1 !ad_oe_o) else $error("write drives ad");
  chk_ignore_other: assert property (
    start_w && !cfg_w |=> devsel_n_o [*3]) else $error("foreign cycle claimed");
  chk_last_release: assert property (
    beat_w && frame_n_i |=> (trdy_n_o && devsel_n_o && !ad_oe_o && ctl_oe_o) ##1 !ctl_oe_o)
    else $error("bad turnaround");
  chk_burst_holds: assert property (
    beat_w && !frame_n_i |=> !trdy_n_o && !devsel_n_o) else $error("burst cut short");
  chk_no_abort: assert property (
    ctl_oe_o |-> stop_n_o) else $error("stop asserted");
  chk_mem_decode: assert property (
    start_w && !idsel_i && cbe_n_i == 4'h6 && ad_i[31:12] == ctrl_o.win_base
    && ctrl_o.mem_space_en |=> mem_hit_o) else $error("window miss");
  chk_mem_off: assert property (
    start_w && !ctrl_o.mem_space_en |=> !mem_hit_o) else $error("hit while disabled");

  // main scenarios
  cover property (cfg_w && !cbe_n_i[0]);
  cover property (cfg_w && cbe_n_i[0]);
  cover property (mem_hit_o);
endmodule

bind pci_config_space_target pci_config_space_target_assertions chk (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .frame_n_i(frame_n_i), .irdy_n_i(irdy_n_i),
  .idsel_i(idsel_i), .cbe_n_i(cbe_n_i), .ad_i(ad_i), .ad_oe_o(ad_oe_o), .trdy_n_o(trdy_n_o),
  .devsel_n_o(devsel_n_o), .stop_n_o(stop_n_o), .ctl_oe_o(ctl_oe_o), .ctrl_o(ctrl_o),
  .mem_hit_o(mem_hit_o));

// File: tb/pci_host_model.sv
// host bridge model issuing configuration and memory cycles
`timescale 1ns/10ps
module pci_host_model (
  // clock and target answers
  input  wire logic   sys_clk_i,
  input  wire logic   trdy_n_i,
  input  wire logic   devsel_n_i,
  // driven pins
  output logic        frame_n_o,
  output logic        irdy_n_o,
  output logic        idsel_o,
  output logic [3:0]  cbe_n_o,
  output logic [31:0] ad_o
);
  // idle bus at time zero
  initial begin
    frame_n_o = 1'b1;
    irdy_n_o = 1'b1;
    idsel_o = 1'b0;
    cbe_n_o = 4'hf;
    ad_o = 32'h0;
  end

  // n data phases, w wait states each; hit tells if the target claimed
  task automatic xfer(input logic [3:0] cmd, input logic sel, input logic [31:0] a,
                      input logic [3:0] be_n, input logic [31:0] wd[16], input int n,
                      input int w, output logic hit);
    int t;
    hit = 1'b0;
    @(negedge sys_clk_i);
    frame_n_o <= 1'b0;
    idsel_o <= sel;
    cbe_n_o <= cmd;
    ad_o <= a;
    for (int k = 0; k < n; k++) begin
      @(negedge sys_clk_i);
      idsel_o <= 1'b0;
      cbe_n_o <= be_n;
      ad_o <= cmd[0] ? wd[k] : ~ad_o;
      if (w > 0) begin
        irdy_n_o <= 1'b1;
        repeat (w) @(negedge sys_clk_i);
      end
      irdy_n_o <= 1'b0;
      frame_n_o <= (k == n - 1);
      t = 0;
      do begin
        @(posedge sys_clk_i);
        t++;
      end while (trdy_n_i !== 1'b0 && t < 8);
      hit |= (devsel_n_i === 1'b0);
    end
    @(negedge sys_clk_i);
    irdy_n_o <= 1'b1;
    frame_n_o <= 1'b1;
    cbe_n_o <= 4'hf;
    ad_o <= ~ad_o;
    repeat (3) @(posedge sys_clk_i);
  endtask
endmodule

// File: tb/pci_config_space_target_tb.sv
// self-checking bench of the configuration target
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module pci_config_space_target_tb;
  // arbitrary identity values
  localparam logic [15:0] DEV_CODE = 16'h1234;
  localparam logic [15:0] VEN_CODE = 16'h5678;
  // pins
  logic                       sys_clk_i;
  logic                       nrst_i;
  logic                       frame_n_i;
  logic                       irdy_n_i;
  logic                       idsel_i;
  logic [3:0]                 cbe_n_i;
  logic [31:0]                ad_i;
  logic [31:0]                host_ad;
  logic [31:0]                ad_o;
  logic                       ad_oe_o;
  logic                       trdy_n_o;
  logic                       devsel_n_o;
  logic                       par_o;
  logic                       par_oe_o;
  logic                       par_exp;
  cfg_target_pkg::status_ev_t status_ev_i;
  cfg_target_pkg::cfg_ctrl_t  ctrl_o;
  logic                       mem_hit_o;
  // bench state
  int                         fail_count;
  int                         cmp_count;
  int                         hit_cnt;
  integer                     seed;
  logic                       c;
  logic [5:0]                 ev;
  logic [31:0]                exp_d;
  logic [31:0]                mdl[64];
  logic [31:0]                wbuf[16];
  logic [31:0]                expq[$];
  int                         tab[5] = '{0, 1, 3, 4, 15};

  // shared wire: target data while it drives, else host pattern
  assign ad_i = ad_oe_o ? ad_o : host_ad;

  pci_config_space_target #(.DEVICE_CODE(DEV_CODE), .VENDOR_CODE(VEN_CODE)) uut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .frame_n_i(frame_n_i), .irdy_n_i(irdy_n_i),
    .idsel_i(idsel_i), .cbe_n_i(cbe_n_i), .ad_i(ad_i), .ad_o(ad_o), .ad_oe_o(ad_oe_o),
    .trdy_n_o(trdy_n_o), .devsel_n_o(devsel_n_o), .stop_n_o(), .ctl_oe_o(), .par_o(par_o),
    .par_oe_o(par_oe_o), .status_ev_i(status_ev_i), .ctrl_o(ctrl_o), .mem_hit_o(mem_hit_o));

  pci_host_model host (
    .sys_clk_i(sys_clk_i), .trdy_n_i(trdy_n_o), .devsel_n_i(devsel_n_o),
    .frame_n_o(frame_n_i), .irdy_n_o(irdy_n_i), .idsel_o(idsel_i), .cbe_n_o(cbe_n_i),
    .ad_o(host_ad));

  // 40 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // writable bits of each dword
  function automatic logic [31:0] rw_mask(int i);
    case (i)
      1: return 32'h0000_0146;
      3: return 32'h0000_ff00;
      4: return 32'hffff_f000;
      15: return 32'h0000_00ff;
      default: return 32'h0;
    endcase
  endfunction

  // apply a write to the expected image, lane by lane
  task automatic model_wr(int i, logic [31:0] d, logic [3:0] be_n);
    logic [31:0] m;
    m = {{8{!be_n[3]}}, {8{!be_n[2]}}, {8{!be_n[1]}}, {8{!be_n[0]}}};
    mdl[i] = (mdl[i] & ~(rw_mask(i) & m)) | (d & rw_mask(i) & m);
    mdl[i] &= ~(d & m & ((i == 1) ? 32'hf900_0000 : 32'h0));
  endtask

  // burst read: expected dwords noted before the cycle
  task automatic cfg_rd(int i, int n, int w);
    logic [31:0] a;
    a = $random(seed);
    a[7:0] = {i[5:0], 2'h0};
    for (int k = 0; k < n; k++) begin
      expq.push_back(mdl[i + k]);
    end
    host.xfer(4'ha, 1'b1, a, 4'h0, wbuf, n, w, c);
    `CHK(c, 1'b1)
  endtask

  // burst write of wbuf with one set of byte enables
  task automatic cfg_wr(int i, int n, logic [3:0] be_n);
    logic [31:0] a;
    a = $random(seed);
    a[7:0] = {i[5:0], 2'h0};
    host.xfer(4'hb, 1'b1, a, be_n, wbuf, n, 0, c);
    `CHK(c, 1'b1)
    for (int k = 0; k < n; k++) begin
      model_wr(i + k, wbuf[k], be_n);
    end
  endtask

  // a cycle the target must leave alone
  task automatic no_claim(logic [3:0] cmd, logic sel, logic [31:0] a);
    host.xfer(cmd, sel, a, 4'h0, wbuf, 1, 0, c);
    `CHK(c, 1'b0)
  endtask

  // read beats checked against the oldest note; window hits counted
  always @(posedge sys_clk_i) begin
    if (!irdy_n_i && trdy_n_o === 1'b0 && ad_oe_o === 1'b1) begin
      exp_d = (expq.size() > 0) ? expq.pop_front() : 32'hx;
      `CHK(ad_o, exp_d)
    end
    hit_cnt += int'(mem_hit_o === 1'b1);
    // parity covers data and byte enables of the previous edge
    if (par_oe_o === 1'b1) begin
      `CHK(par_o, par_exp)
    end
    par_exp = ^{ad_o, cbe_n_i};
  end

  // verdict and end of run
  task automatic finish_test();
    $display("Compares %0d, errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles of the run
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    $display("Error at %0t: timeout %h %h", $time, 0, 1);
    finish_test();
  end

  // main sequence
  initial begin
    seed = 32'hdadd;
    nrst_i = 1'b0;
    status_ev_i = '0;
    repeat (16) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    nrst_i = 1'b1;
    mdl = '{default: 32'h0};
    mdl[0] = {DEV_CODE, VEN_CODE};
    mdl[1] = 32'h0280_0000;
    mdl[2] = 32'h0400_0000;
    mdl[4] = 32'h0000_0008;
    mdl[15] = 32'h0000_0100;
    cfg_rd(0, 17, 0);
    no_claim(4'h6, 1'b0, 32'h0);
    no_claim(4'ha, 1'b0, 32'h0);
    no_claim(4'ha, 1'b1, 32'h1);
    no_claim(4'h6, 1'b1, 32'h0);
    `CHK(hit_cnt, 0)
    wbuf = '{default: 32'hffff_ffff};
    cfg_wr(0, 16, 4'h0);
    cfg_rd(0, 16, 1);
    no_claim(4'h6, 1'b0, 32'hffff_f124);
    `CHK(hit_cnt, 1)
    repeat (12) begin
      ev = 6'($random(seed));
      @(negedge sys_clk_i);
      status_ev_i = cfg_target_pkg::status_ev_t'(ev);
      @(negedge sys_clk_i);
      status_ev_i = '0;
      mdl[1] |= {ev[5:1], 2'h0, ev[0], 24'h0};
      wbuf[0] = $random(seed);
      exp_d = $random(seed);
      cfg_wr(tab[exp_d[15:0] % 5], 1, exp_d[19:16]);
      cfg_rd(tab[exp_d[15:0] % 5], 1, 2);
    end
    `CHK(expq.size(), 0)
    finish_test();
  end
endmodule
